// ---- rtl/blit_engine.v ----
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "blit_consts.vh"

module blit_engine #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
)(
  // Clock, reset and enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // AXI4-Lite write
  input wire [11:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [11:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Display memory
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [23:0] mem_wdata,
  input wire mem_ack,
  input wire [23:0] mem_rdata
);

  localparam ST_IDLE = 3'b000;
  localparam ST_SRC = 3'b001;
  localparam ST_SRC1 = 3'b010;
  localparam ST_WRITE = 3'b011;
  localparam ST_NEXT = 3'b100;

  // ****************************************
  // Colour helpers and bus index decode
  // ****************************************

  // Widen a stored pixel to 8 bits per channel.
  function [23:0] expand;
    input [23:0] p;
    input [1:0] d;
    begin
      if (d == `D_8)
        expand = {p[7:5], p[7:5], p[7:6], p[4:2], p[4:2], p[4:3],
          p[1:0], p[1:0], p[1:0], p[1:0]};
      else if (d == `D_16)
        expand = {p[15:11], p[15:13], p[10:5], p[10:9], p[4:0], p[4:2]};
      else
        expand = p;
    end
  endfunction

  // Narrow an 8-bit-per-channel colour to the destination format.
  function [23:0] pack;
    input [23:0] c;
    input [1:0] d;
    begin
      if (d == `D_8)
        pack = {16'h0000, c[23:21], c[15:13], c[7:6]};
      else if (d == `D_16)
        pack = {8'h00, c[23:19], c[15:10], c[7:3]};
      else
        pack = c;
    end
  endfunction

  // Bytes one pixel takes in memory.
  function [31:0] step;
    input [1:0] d;
    begin
      step = (d == `D_8) ? 32'h1 : (d == `D_16) ? 32'h2 : 32'h3;
    end
  endfunction

  // One channel of the blend; a full alpha keeps the first source.
  function [7:0] mix;
    input [7:0] a;
    input [7:0] b;
    input [7:0] al;
    reg [16:0] s;
    begin
      s = a * al + b * (`ALPHA_FULL - al) + {9'h0, `ALPHA_FULL};
      mix = s[15:8];
    end
  endfunction

  // Indices that answer on the bus.
  function mapped;
    input [9:0] ix;
    begin
      mapped = (ix >= `IX_OPCODE && ix <= `IX_S0X1) ||
        (ix >= `IX_CTRL && ix <= `IX_S1A);
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [3:0] opcode;
  reg [1:0] s0_depth;
  reg [2:0] s1_depth;
  reg [1:0] dst_depth;
  reg [29:0] s0_start;
  reg [10:0] s0_width;
  reg [12:0] s0_left;
  reg [15:0] count;
  reg [23:0] fg;
  reg [31:0] dest;
  reg [7:0] alpha;
  reg [31:0] s1_start;
  reg aw_full;
  reg w_full;
  reg [9:0] aw_ix;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] state;
  reg [15:0] left;
  reg [31:0] src_addr;
  reg [31:0] s1_addr;
  reg [31:0] dst_addr;
  reg [23:0] s0_pix;
  reg [23:0] s1_pix;
  reg [7:0] pix_alpha;
  reg [7:0] bits;
  reg [2:0] bit_ix;
  reg [31:0] rd_word;
  reg [23:0] out_pix;
  wire [31:0] mask;
  wire [9:0] rix;
  wire host_wr;
  wire do_wr;
  wire start_req;
  wire busy;
  wire [1:0] s1_fmt;
  wire [7:0] use_alpha;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [31:0] fifo_out_data;

  // ****************************************
  // Bus slave
  // ****************************************

  // Address and data are held apart, so either may arrive first.
  assign awready = ce & ~aw_full;
  assign wready = ce & ~w_full;
  assign arready = ce & ~rvalid;
  assign rix = araddr[11:2];
  assign host_wr = aw_ix == `IX_HOST;
  // A full FIFO stalls the response, pushing back on the host.
  assign fifo_in_valid = ce & aw_full & w_full & ~bvalid & host_wr;
  assign do_wr = ce & aw_full & w_full & ~bvalid &
    (~host_wr | fifo_in_ready);
  assign mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
    {8{w_strb[0]}}};
  assign start_req = do_wr & (aw_ix == `IX_CTRL) & w_strb[0] & w_data[0];
  assign busy = state != ST_IDLE;

  // Write channel bookkeeping and the response.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_ix <= 10'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_full <= 1'b1;
        aw_ix <= awaddr[11:2];
      end
      if (wvalid && wready)
      begin
        w_full <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_wr)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_ix) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Register writes; byte registers take lane 0 only.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opcode <= 4'h0;
      s0_depth <= 2'h0;
      s1_depth <= 3'h0;
      dst_depth <= 2'h0;
      s0_start <= 30'h0000_0000;
      s0_width <= 11'h000;
      s0_left <= 13'h0000;
      count <= 16'h0000;
      fg <= 24'h00_0000;
      dest <= 32'h0000_0000;
      alpha <= 8'h00;
      s1_start <= 32'h0000_0000;
    end
    else if (do_wr)
    begin
      if (w_strb[0])
      begin
        if (aw_ix == `IX_OPCODE)
          opcode <= w_data[3:0];
        else if (aw_ix == `IX_DEPTHS)
        begin
          s0_depth <= w_data[`F_S0D];
          s1_depth <= w_data[`F_S1D];
          dst_depth <= w_data[`F_DD];
        end
        else if (aw_ix == `IX_S0A0)
          s0_start[5:0] <= w_data[7:2];
        else if (aw_ix == `IX_S0A1)
          s0_start[13:6] <= w_data[7:0];
        else if (aw_ix == `IX_S0A2)
          s0_start[21:14] <= w_data[7:0];
        else if (aw_ix == `IX_S0A3)
          s0_start[29:22] <= w_data[7:0];
        else if (aw_ix == `IX_S0W0)
          s0_width[5:0] <= w_data[7:2];
        else if (aw_ix == `IX_S0W1)
          s0_width[10:6] <= w_data[4:0];
        else if (aw_ix == `IX_S0X0)
          s0_left[7:0] <= w_data[7:0];
        else if (aw_ix == `IX_S0X1)
          s0_left[12:8] <= w_data[4:0];
        else if (aw_ix == `IX_ALPHA)
          alpha <= w_data[7:0];
      end
      if (aw_ix == `IX_COUNT)
        count <= (count & ~mask[15:0]) | (w_data[15:0] & mask[15:0]);
      else if (aw_ix == `IX_FG)
        fg <= (fg & ~mask[23:0]) | (w_data[23:0] & mask[23:0]);
      else if (aw_ix == `IX_DEST)
        dest <= (dest & ~mask) | (w_data & mask);
      else if (aw_ix == `IX_S1A)
        s1_start <= (s1_start & ~mask) | (w_data & mask);
    end
  end

  // Read data; unused bits come back as zero.
  always @*
  begin
    rd_word = 32'h0000_0000;
    if (rix == `IX_OPCODE)
      rd_word[3:0] = opcode;
    else if (rix == `IX_DEPTHS)
      rd_word[7:0] = {1'b0, s0_depth, s1_depth, dst_depth};
    else if (rix == `IX_S0A0)
      rd_word[7:0] = {s0_start[5:0], 2'b00};
    else if (rix == `IX_S0A1)
      rd_word[7:0] = s0_start[13:6];
    else if (rix == `IX_S0A2)
      rd_word[7:0] = s0_start[21:14];
    else if (rix == `IX_S0A3)
      rd_word[7:0] = s0_start[29:22];
    else if (rix == `IX_S0W0)
      rd_word[7:0] = {s0_width[5:0], 2'b00};
    else if (rix == `IX_S0W1)
      rd_word[4:0] = s0_width[10:6];
    else if (rix == `IX_S0X0)
      rd_word[7:0] = s0_left[7:0];
    else if (rix == `IX_S0X1)
      rd_word[4:0] = s0_left[12:8];
    else if (rix == `IX_CTRL)
      rd_word[0] = busy;
    else if (rix == `IX_COUNT)
      rd_word = {left, count};
    else if (rix == `IX_FG)
      rd_word[23:0] = fg;
    else if (rix == `IX_DEST)
      rd_word = dest;
    else if (rix == `IX_ALPHA)
      rd_word[7:0] = alpha;
    else if (rix == `IX_S1A)
      rd_word = s1_start;
  end

  // Read answer one edge after the address is taken.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= mapped(rix) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Transfer engine
  // ****************************************

  // Host words for the first source queue here.
  blit_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(w_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign fifo_out_ready = ce & (state == ST_SRC) &
    (opcode == `OP_OPACITY);
  // Alpha modes read 8 or 16 bit second source pixels.
  assign s1_fmt = s1_depth[2] ? {1'b0, s1_depth[0]} : s1_depth[1:0];
  assign use_alpha = (s1_depth == `S1_A8 || s1_depth == `S1_A16) ?
    pix_alpha : alpha;

  // Value written to the destination pixel.
  always @*
  begin
    out_pix = s0_pix;
    if (opcode == `OP_FILL || opcode == `OP_EXPAND_KEY)
      out_pix = fg;
    else if (opcode == `OP_OPACITY)
      out_pix = {mix(s0_pix[23:16], s1_pix[23:16], use_alpha),
        mix(s0_pix[15:8], s1_pix[15:8], use_alpha),
        mix(s0_pix[7:0], s1_pix[7:0], use_alpha)};
  end

  // Pixels run linearly from the start addresses, one at a time.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      left <= 16'h0000;
      src_addr <= 32'h0000_0000;
      s1_addr <= 32'h0000_0000;
      dst_addr <= 32'h0000_0000;
      s0_pix <= 24'h00_0000;
      s1_pix <= 24'h00_0000;
      pix_alpha <= 8'h00;
      bits <= 8'h00;
      bit_ix <= 3'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 24'h00_0000;
    end
    else if (ce)
    begin
      case (state)
        ST_IDLE:
          if (start_req && count != 16'h0000)
          begin
            left <= count;
            src_addr <= {s0_start, 2'b00};
            s1_addr <= s1_start;
            dst_addr <= dest;
            bit_ix <= 3'h0;
            // Reserved and other codes end at once with no write.
            if (opcode == `OP_FILL)
              state <= ST_WRITE;
            else if (opcode == `OP_OPACITY || opcode == `OP_EXPAND ||
              opcode == `OP_EXPAND_KEY)
              state <= ST_SRC;
          end
        ST_SRC:
          if (opcode == `OP_OPACITY)
          begin
            if (fifo_out_valid)
            begin
              s0_pix <= expand(fifo_out_data[23:0], s0_depth);
              pix_alpha <= fifo_out_data[`F_ALPHA];
              // A constant second source needs no memory read.
              if (s1_depth == `S1_CONST)
              begin
                s1_pix <= {s1_start[7:0], s1_start[15:8],
                  s1_start[23:16]};
                state <= ST_WRITE;
              end
              else
                state <= ST_SRC1;
            end
          end
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= src_addr;
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            if (opcode == `OP_EXPAND_KEY)
            begin
              bits <= mem_rdata[7:0];
              src_addr <= src_addr + 32'h1;
            end
            else
            begin
              s0_pix <= expand(mem_rdata, s0_depth);
              src_addr <= src_addr + step(s0_depth);
            end
            state <= ST_WRITE;
          end
        ST_SRC1:
          if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= s1_addr;
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            s1_pix <= expand(mem_rdata, s1_fmt);
            s1_addr <= s1_addr + step(s1_fmt);
            state <= ST_WRITE;
          end
        ST_WRITE:
          if (opcode == `OP_EXPAND_KEY && !bits[bit_ix])
          begin
            dst_addr <= dst_addr + step(dst_depth);
            state <= ST_NEXT;
          end
          else if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= dst_addr;
            mem_wdata <= pack(out_pix, dst_depth);
          end
          else if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            dst_addr <= dst_addr + step(dst_depth);
            state <= ST_NEXT;
          end
        ST_NEXT:
        begin
          left <= left - 16'h0001;
          bit_ix <= bit_ix + 3'h1;
          if (left == 16'h0001)
            state <= ST_IDLE;
          else if (opcode == `OP_FILL ||
            (opcode == `OP_EXPAND_KEY && bit_ix != 3'h7))
            state <= ST_WRITE;
          else
            state <= ST_SRC;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule // blit_engine

`default_nettype wire

// ---- rtl/blit_consts.vh ----
// Summary of operation
// - Code 1011b blends host-written first source with second source from memory.
// - Code 1100b fills every destination pixel with the colour register value.
// - Code 1110b reads first source, expands colour, writes destination.
// - Code 1111b writes foreground for one bits and skips zero bits.
// - First source and destination depth: 00 8bpp, 01 16bpp, 1x 24bpp.
// - Second source depth: 000 8bpp, 001 16bpp, 010 24bpp.
// - Second source code 011 turns its start address into a constant colour.
// - Second source codes 100 and 101 give per-pixel alpha, 8/16-bit pixels.
// - First source start built from four bytes, low first, bits 1:0 zero.
// - First source left edge is 13 bits over two bytes, top three unused.
`ifndef BLIT_CONSTS_VH
`define BLIT_CONSTS_VH

// ****************************************
// Register indices; byte address is 4x.
// ****************************************
`define IX_OPCODE 10'h091
`define IX_DEPTHS 10'h092
`define IX_S0A0 10'h093
`define IX_S0A1 10'h094
`define IX_S0A2 10'h095
`define IX_S0A3 10'h096
`define IX_S0W0 10'h097
`define IX_S0W1 10'h098
`define IX_S0X0 10'h099
`define IX_S0X1 10'h09A
`define IX_CTRL 10'h0C0
`define IX_COUNT 10'h0C1
`define IX_FG 10'h0C2
`define IX_DEST 10'h0C3
`define IX_HOST 10'h0C4
`define IX_ALPHA 10'h0C5
`define IX_S1A 10'h0C6

// ****************************************
// Fields and codes.
// ****************************************
`define F_S0D 6:5
`define F_S1D 4:2
`define F_DD 1:0
`define F_ALPHA 31:24
`define OP_OPACITY 4'hB
`define OP_FILL 4'hC
`define OP_EXPAND 4'hE
`define OP_EXPAND_KEY 4'hF
`define D_8 2'h0
`define D_16 2'h1
`define S1_CONST 3'h3
`define S1_A8 3'h4
`define S1_A16 3'h5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ALPHA_FULL 8'hFF

`endif

// ---- rtl/blit_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

module blit_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
)(
  // Clock, reset and enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] fill;
  wire push;
  wire pop;

  // Ready and valid are gated by the enable so a frozen FIFO moves nothing.
  assign in_ready = ce & (fill != DEPTH[AW:0]);
  assign out_valid = ce & (fill != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // Pointers wrap by hand so DEPTH need not be a power of two.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end
    else if (ce)
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_ptr + 1'b1;
      if (push && !pop)
        fill <= fill + 1'b1;
      else if (pop && !push)
        fill <= fill - 1'b1;
    end
  end

endmodule // blit_fifo

`default_nettype wire

// ---- sim/blit_engine_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "blit_consts.vh"

module blit_engine_assertions #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
)(
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Register bus
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // Display memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  input wire logic mem_ack
);
  // ****************************************
  // Bus and memory checks
  // ****************************************
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Host pushes may stall on a full buffer, so they are left out here.
  sequence wr_taken;
    awvalid && awready && wvalid && wready && awaddr[11:2] != `IX_HOST;
  endsequence
  sequence rd_taken(ix);
    arvalid && arready && araddr[11:2] == ix;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer missing");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("second read taken while answer pending");
  addr_low_a: assert property (rd_taken(`IX_S0A0) |=> rdata[1:0] == 2'h0)
    else $error("start address low bits not zero");
  left_high_a: assert property (rd_taken(`IX_S0X1) |=> rdata[7:5] == 3'h0)
    else $error("left edge unused bits not zero");
  depth_top_a: assert property (rd_taken(`IX_DEPTHS) |=> !rdata[7])
    else $error("depth register top bit not zero");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req &&
    $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  mem_drop_a: assert property (mem_req && mem_ack && ce |=> !mem_req)
    else $error("memory request held after ack");
  // Reset itself is the cause here, so this one is never disabled.
  reset_idle_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn && ce |=> !bvalid && !rvalid && !mem_req)
    else $error("outputs busy after reset");
endmodule // blit_engine_assertions

`default_nettype wire

// ---- sim/blit_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module blit_mem_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  output logic mem_ack,
  output logic [23:0] mem_rdata
);
  // Counters the bench reads to judge each operation.
  int wr_count = 0;
  int rd_count = 0;
  logic [23:0] last_wdata = 24'h0;
  int wait_n = 0;

  // Answers two to four cycles after a request; read data is only valid with ack,
  // so it toggles between answers to expose a late sample.
  always @(posedge aclk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!aresetn)
      wait_n <= 0;
    else if (mem_req && !mem_ack)
    begin
      if (wait_n == 0)
        wait_n <= 1 + $urandom % 3;
      else if (wait_n == 1)
      begin
        mem_ack <= 1'b1;
        wait_n <= 0;
        mem_rdata <= 24'h0000A5;
        if (mem_we)
        begin
          wr_count <= wr_count + 1;
          last_wdata <= mem_wdata;
        end
        else
          rd_count <= rd_count + 1;
      end
      else
        wait_n <= wait_n - 1;
    end
  end
endmodule // blit_mem_model

`default_nettype wire

// ---- sim/blit_engine_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "blit_consts.vh"

module blit_engine_tb_top;
  localparam FIFO_DEPTH = 4;
  localparam FIFO_AW = 2;
  // Bus side stimulus; response readies come late so answers must hold.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic mem_req, mem_we, mem_ack;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, mem_addr;
  wire logic [23:0] mem_wdata, mem_rdata;
  int mismatches = 0;
  int samples_checked = 0;
  logic [31:0] rv, w0, fg;
  logic [1:0] rs;
  logic [3:0] op;
  int cnt, base;

  // Free-running 125 MHz bus clock.
  always #4 aclk = ~aclk;

  blit_engine #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) blit_engine_inst (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  blit_mem_model blit_mem_model_inst (
    .aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic tally_and_finish();
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data are offered together and each released when taken.
  task automatic axi_wr(input logic [9:0] ix, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= {ix, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n == 3) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready) && n < 500);
    r = bresp;
    if (n >= 500) begin mismatches++; tally_and_finish(); end
  endtask

  task automatic axi_rd(input logic [9:0] ix, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    araddr <= {ix, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n == 2) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready) && n < 500);
    d = rdata;
    r = rresp;
    if (n >= 500) begin mismatches++; tally_and_finish(); end
  endtask

  // Read-back value of a register after writing d to it.
  function automatic logic [31:0] rmask(input logic [9:0] ix,
                                        input logic [31:0] d);
    case (ix)
      `IX_OPCODE: rmask = {28'h0, d[3:0]};
      `IX_DEPTHS: rmask = {25'h0, d[6:0]};
      `IX_S0A0, `IX_S0W0: rmask = {24'h0, d[7:2], 2'h0};
      `IX_S0W1, `IX_S0X1: rmask = {27'h0, d[4:0]};
      default: rmask = {24'h0, d[7:0]};
    endcase
  endfunction

  // Pixel writes expected; mono expansion skips the zero bits of 8'hA5.
  function automatic int exp_writes(input logic [3:0] o, input int n);
    exp_writes = (o == `OP_EXPAND_KEY) ? $countones(8'hA5 & ((1 << n) - 1)) : n;
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(33));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Fields from opcode to left edge read zero out of reset, then keep only their live bits.
    for (int i = `IX_OPCODE; i <= `IX_S0X1; i++)
    begin
      axi_rd(i[9:0], rv, rs);
      chk(rv, 32'h0);
      for (int k = 0; k < 3; k++)
      begin
        w0 = (k == 0) ? 32'hFFFFFFFF : $urandom;
        axi_wr(i[9:0], w0, rs);
        chk({30'h0, rs}, {30'h0, `RESP_OKAY});
        axi_rd(i[9:0], rv, rs);
        chk(rv, rmask(i[9:0], w0));
      end
    end
    // Unmapped place: write ignored, read zero, both refused.
    axi_wr(10'h3FF, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    axi_rd(10'h3FF, rv, rs);
    chk(rv, 32'h0);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    // Each working code once, then the reserved one, destination alternating between the two 24bpp codes.
    for (int j = 0; j < 5; j++)
    begin
      op = (j == 4) ? 4'hD : (j < 2) ? 4'hB + j[3:0] : 4'hC + j[3:0];
      cnt = 1 + $urandom % 8;
      fg = {8'h0, $urandom} & 32'h00FFFFFF;
      axi_wr(`IX_OPCODE, {28'h0, op}, rs);
      // The blend runs with a constant second source and zero alpha.
      axi_wr(`IX_DEPTHS, {27'h0, ((op == `OP_OPACITY) ? `S1_CONST : 3'h0),
                          1'b1, j[0]}, rs);
      axi_wr(`IX_FG, fg, rs);
      axi_wr(`IX_S1A, fg, rs);
      axi_wr(`IX_DEST, $urandom & 32'hFFFFFFFC, rs);
      axi_wr(`IX_COUNT, cnt, rs);
      base = blit_mem_model_inst.wr_count;
      axi_wr(`IX_CTRL, 32'h1, rs);
      // Host words cross the 4-deep buffer, stalling while it is full.
      if (op == `OP_OPACITY)
        for (int h = 0; h < cnt; h++)
          axi_wr(`IX_HOST, $urandom, rs);
      for (int n = 0; n < 100; n++)
      begin
        axi_rd(`IX_CTRL, rv, rs);
        if (rv[0] === 1'b0) break;
      end
      chk(rv[0], 1'b0);
      if (rv[0] !== 1'b0) tally_and_finish();
      if (op == 4'hD)
        chk(blit_mem_model_inst.wr_count - base, 0);
      else
        chk(blit_mem_model_inst.wr_count - base, exp_writes(op, cnt));
      if (op == `OP_FILL || op == `OP_EXPAND_KEY)
        chk({8'h0, blit_mem_model_inst.last_wdata}, fg);
      if (op == `OP_OPACITY)
      begin
        w0 = {8'h0, fg[7:0], fg[15:8], fg[23:16]};
        chk({8'h0, blit_mem_model_inst.last_wdata}, w0);
      end
    end
    chk(blit_mem_model_inst.rd_count > 0, 1'b1);
    tally_and_finish();
  end
endmodule // blit_engine_tb_top

bind blit_engine blit_engine_assertions #(
  .FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) blit_engine_assertions_inst (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack));

`default_nettype wire
